/* verilog/arc_pkg.sv */
// ---------------------------------------------------------------------------
// Constants for the range / reference / interface configuration block
// ---------------------------------------------------------------------------
package arc_pkg;

  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Control register
  localparam logic [7:0] OFS_STATUS = 8'h04;  // Live configuration, busy
  localparam logic [7:0] OFS_RESULT = 8'h08;  // Last coded result

  // Control register fields (bit 7 maps to DB15 ... bit 0 to DB8)
  localparam int CTRL_W      = 8;
  localparam int FLD_SEL_LO  = 5;             // Pair sampling selects
  localparam int FLD_RNG_LO  = 2;             // Range bits, pair one at LSB
  localparam int FLD_REF_ON  = 1;             // Internal reference on
  localparam int FLD_BUF_DIS = 0;             // Reference buffers off
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields
  localparam int ST_BUSY     = 0;
  localparam int ST_RNG_LO   = 1;             // Three live range bits
  localparam int ST_REF_ON   = 4;
  localparam int ST_BUF_LO   = 5;             // Three buffer enables
  localparam int ST_WORD     = 8;
  localparam int ST_BYTE     = 9;
  localparam int ST_SERIAL   = 10;
  localparam int ST_DAISY    = 11;
  localparam int ST_SW_MODE  = 12;

  // Geometry
  localparam int PAIRS       = 3;
  localparam int RES_W       = 16;            // Output word width
  localparam int SAMPLE_W    = 17;            // Input in half 16-bit steps
  localparam int RES_16      = 16;
  localparam int RES_14      = 14;
  localparam int RES_12      = 12;

  // Conversion time
  localparam int CLK_MHZ     = 125;
  localparam int T_CONV_NS   = 3000;
  localparam int CONV_CYCLES = (T_CONV_NS * CLK_MHZ) / 1000;
  localparam int CNT_W       = 9;

  // Conversion sequencer states
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_RUN  = 2'b10
  } arc_conv_type;

endpackage

/* verilog/arc_config.sv */
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Range one selects plus/minus two Vref
// (R2) Range zero selects plus/minus four Vref
// (R3) Range changes apply at next conversion
// (R4) Results coded in twos complement
// (R5) Step is range over 2^resolution
// (R6) Transitions at half-step points, rounding
// (R7) Reset: external ref, buffers enabled
// (R8) Hardware mode: enable pin turns ref on
// (R9) Software mode: control bit ref on
// (R10) Software mode: control bit disables buffers
// (R11) Serial hardware mode: pin disables buffers
// (R12) Three buffers, one per pair
// (R13) Host keeps internal ref off externally
// (R14) Serial/parallel chosen by select pin
// (R15) Word/byte pin picks parallel width
// (R16) Serial mode supports daisy chain
// (R17) Control layout: range, ref, buffer bits
// (R18) Control byte latched on write rising
// (R19) Control register resets to zero
// (R20) Busy high for full conversion time
// (R21) Pin ranges all; bits per pair
module arc_config #(
  parameter int RES_BITS = arc_pkg::RES_16
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          reset,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [arc_pkg::ADDR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [arc_pkg::DATA_W-1:0]    wb_dat_i,
  output logic      [arc_pkg::DATA_W-1:0]    wb_dat_o,
  output logic                               wb_ack_o,
  // Strap and control pins
  input  wire logic                          range_pin,
  input  wire logic                          hw_sw_select,
  input  wire logic                          internal_ref_enable_pin,
  input  wire logic                          buffer_disable_pin,
  input  wire logic                          serial_parallel_select,
  input  wire logic                          word_byte_select,
  input  wire logic                          daisy_chain_pin,
  input  wire logic                          conversion_trigger,
  // Parallel control write pins
  input  wire logic                          cs_n,
  input  wire logic                          wr_n,
  input  wire logic                          rd_n,
  input  wire logic [arc_pkg::CTRL_W-1:0]    db_upper,
  // Sampled analog value, half 16-bit steps of full scale
  input  wire logic [arc_pkg::SAMPLE_W-1:0]  sample_in,
  // Configuration outputs
  output logic      [arc_pkg::PAIRS-1:0]     pair_range_active,
  output logic                               internal_ref_on,
  output logic      [arc_pkg::PAIRS-1:0]     ref_buffer_enable,
  output logic                               parallel_word_mode,
  output logic                               parallel_byte_mode,
  output logic                               serial_mode,
  output logic                               daisy_chain_mode,
  output logic                               busy,
  output logic      [arc_pkg::RES_W-1:0]     result_code
);
  import arc_pkg::*;

  // -------------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------------
  // Round a half-step sample to the variant resolution, twos complement
  function automatic logic [RES_W-1:0] code_of(
    input logic [SAMPLE_W-1:0] s
  );
    logic signed [SAMPLE_W:0] wide;
    logic signed [SAMPLE_W:0] q;
    logic signed [SAMPLE_W:0] top;
    logic [RES_W-1:0]         mask;
    int                       sh;
    wide = {s[SAMPLE_W-1], s};
    sh   = SAMPLE_W - RES_BITS;
    top  = (SAMPLE_W+1)'(((1 << (RES_BITS-1)) - 1));
    mask = RES_W'((1 << RES_BITS) - 1);
    q    = (wide + (SAMPLE_W+1)'(1 << (sh-1))) >>> sh;
    if (q > top) begin
      q = top;
    end
    code_of = q[RES_W-1:0] & mask;
  endfunction

  // -------------------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------------------
  localparam int SYN_W = 11 + CTRL_W;
  logic [SYN_W-1:0] syn_a;          // First stage, read only by second
  logic [SYN_W-1:0] syn_b;          // Second stage, usable
  logic [SYN_W-1:0] next_syn_a;
  logic [SYN_W-1:0] next_syn_b;
  logic             wr_n_prev;      // Last synchronised write strobe
  logic             trig_prev;      // Last synchronised trigger
  logic             next_wr_n_prev;
  logic             next_trig_prev;

  // Synchronised views
  logic             s_range, s_hwsw, s_refpin, s_bufpin, s_ser, s_wb;
  logic             s_daisy, s_trig, s_cs_n, s_wr_n, s_rd_n;
  logic [CTRL_W-1:0] s_db;
  assign {s_range, s_hwsw, s_refpin, s_bufpin, s_ser, s_wb, s_daisy,
          s_trig, s_cs_n, s_wr_n, s_rd_n, s_db} = syn_b;

  // Next values of the synchronisers
  always_comb begin
    next_syn_a = {range_pin, hw_sw_select, internal_ref_enable_pin,
                  buffer_disable_pin, serial_parallel_select,
                  word_byte_select, daisy_chain_pin, conversion_trigger,
                  cs_n, wr_n, rd_n, db_upper};
    next_syn_b     = syn_a;
    next_wr_n_prev = s_wr_n;
    next_trig_prev = s_trig;
  end

  // Register the synchronisers; no reset, so they follow the pins while
  // reset is held and the edge detectors see no false edge at release
  always_ff @(posedge sys_clk) begin
    syn_a     <= next_syn_a;
    syn_b     <= next_syn_b;
    wr_n_prev <= next_wr_n_prev;
    trig_prev <= next_trig_prev;
  end

  // -------------------------------------------------------------------------
  // Control register and Wishbone slave
  // -------------------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;          // DB15..DB8 image
  logic [CTRL_W-1:0] next_ctrl;
  logic              next_ack;
  logic [DATA_W-1:0] next_dat;
  logic              wb_req;
  logic              pin_write;
  logic [DATA_W-1:0] status_word;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // (R18) Write strobe rising edge
  assign pin_write = ~wr_n_prev & s_wr_n & ~s_cs_n & s_rd_n;

  // Status image of live configuration
  always_comb begin
    status_word                               = '0;
    status_word[ST_BUSY]                      = busy;
    status_word[ST_RNG_LO +: PAIRS]           = pair_range_active;
    status_word[ST_REF_ON]                    = internal_ref_on;
    status_word[ST_BUF_LO +: PAIRS]           = ref_buffer_enable;
    status_word[ST_WORD]                      = parallel_word_mode;
    status_word[ST_BYTE]                      = parallel_byte_mode;
    status_word[ST_SERIAL]                    = serial_mode;
    status_word[ST_DAISY]                     = daisy_chain_mode;
    status_word[ST_SW_MODE]                   = s_hwsw;
  end

  // Next values of register and bus answer
  always_comb begin
    next_ctrl = ctrl;
    next_ack  = wb_req;
    next_dat  = '0;
    // (R18) Pin write latches the upper byte
    if (pin_write) begin
      next_ctrl = s_db;
    end
    // (R17) Range, reference, buffer bits
    // Bus write to control, low byte lane
    if (wb_req && wb_we_i && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
      next_ctrl = wb_dat_i[CTRL_W-1:0];
    end
    // Read data; unmapped reads return zero
    if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        OFS_CTRL:   next_dat = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
        OFS_STATUS: next_dat = status_word;
        OFS_RESULT: next_dat = {{(DATA_W-RES_W){1'b0}}, result_code};
        default:    next_dat = '0;
      endcase
    end
  end

  // Register control byte and bus outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      // (R19) Control register cleared
      ctrl     <= CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ctrl     <= next_ctrl;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // -------------------------------------------------------------------------
  // Reference, buffers and interface mode
  // -------------------------------------------------------------------------
  logic             next_ref_on;
  logic             buf_off;
  logic [PAIRS-1:0] next_buf_en;
  logic             next_word, next_byte, next_serial, next_daisy;

  // Decide reference and interface settings
  always_comb begin
    // (R8) Hardware mode reference pin
    next_ref_on = s_refpin;
    // (R11) Serial hardware buffer disable
    buf_off     = s_ser & s_bufpin;
    if (s_hwsw) begin
      // (R9) Software reference enable bit
      next_ref_on = ctrl[FLD_REF_ON];
      // (R10) Software buffer disable bit
      buf_off     = ctrl[FLD_BUF_DIS];
    end
    // (R14) Serial or parallel selection
    next_serial = s_ser;
    // (R15) Word or byte parallel width
    next_word   = ~s_ser & ~s_wb;
    next_byte   = ~s_ser & s_wb;
    // (R16) Daisy chain in serial mode
    next_daisy  = s_ser & s_daisy;
  end

  // (R12) One buffer enable per pair
  genvar gp;
  generate
    for (gp = 0; gp < PAIRS; gp++) begin : g_buf
      assign next_buf_en[gp] = ~buf_off;
    end
  endgenerate

  // Register reference and mode outputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      // (R7) External reference, buffers on
      internal_ref_on    <= 1'b0;
      ref_buffer_enable  <= '1;
      parallel_word_mode <= 1'b1;
      parallel_byte_mode <= 1'b0;
      serial_mode        <= 1'b0;
      daisy_chain_mode   <= 1'b0;
    end else begin
      internal_ref_on    <= next_ref_on;
      ref_buffer_enable  <= next_buf_en;
      parallel_word_mode <= next_word;
      parallel_byte_mode <= next_byte;
      serial_mode        <= next_serial;
      daisy_chain_mode   <= next_daisy;
    end
  end

  // -------------------------------------------------------------------------
  // Conversion sequencer
  // -------------------------------------------------------------------------
  arc_conv_type      state, next_state;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [PAIRS-1:0]  next_range;
  logic [PAIRS-1:0]  range_req;     // Range that the next start will use
  logic              next_busy;
  logic [RES_W-1:0]  next_result;
  logic              start;

  assign start = ~trig_prev & s_trig;

  // (R21) Pin for all pairs, bits per pair
  assign range_req = s_hwsw ? ctrl[FLD_RNG_LO +: PAIRS] : {PAIRS{s_range}};

  // Next sequencer values
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_range  = pair_range_active;
    next_busy   = busy;
    next_result = result_code;
    unique case (state)
      CONV_IDLE: begin
        if (start) begin
          // (R3) Range frozen at conversion start
          // (R1) (R2) One narrow, zero wide range
          next_range = range_req;
          // (R4) (R5) (R6) Rounded twos complement
          next_result = code_of(sample_in);
          next_cnt    = CNT_W'(CONV_CYCLES - 1);
          next_busy   = 1'b1;
          next_state  = CONV_RUN;
        end
      end
      CONV_RUN: begin
        // (R20) Busy held for conversion time
        if (cnt == '0) begin
          next_busy  = 1'b0;
          next_state = CONV_IDLE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
    endcase
  end

  // Register sequencer state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state             <= CONV_IDLE;
      cnt               <= '0;
      pair_range_active <= '0;
      busy              <= 1'b0;
      result_code       <= '0;
    end else begin
      state             <= next_state;
      cnt               <= next_cnt;
      pair_range_active <= next_range;
      busy              <= next_busy;
      result_code       <= next_result;
    end
  end

endmodule

/* tb/arc_config_sva.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module arc_config_sva
  import arc_pkg::*;
(
  // Clock, reset, bus handshake
  input wire logic             sys_clk,
  input wire logic             reset,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_ack_o,
  // Configuration and conversion outputs
  input wire logic [PAIRS-1:0] pair_range_active,
  input wire logic [PAIRS-1:0] ref_buffer_enable,
  input wire logic             parallel_word_mode,
  input wire logic             parallel_byte_mode,
  input wire logic             serial_mode,
  input wire logic             daisy_chain_mode,
  input wire logic             busy,
  input wire logic [RES_W-1:0] result_code
);
  logic [CNT_W-1:0] cnt;       // Cycles busy has been high
  logic [CNT_W-1:0] next_cnt;  // Next count
  // Count busy cycles, clear when idle
  always_comb begin
    next_cnt = busy ? cnt + 1'b1 : '0;
  end
  always_ff @(posedge sys_clk) begin
    cnt <= reset ? '0 : next_cnt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_busy_len: assert property ($fell(busy) |-> cnt == CONV_CYCLES)
    else $error("busy length wrong");
  a_busy_max: assert property (busy |-> cnt < CONV_CYCLES)
    else $error("busy too long");
  a_conv_hold: assert property (busy ##1 busy |->
    $stable(pair_range_active) && $stable(result_code))
    else $error("range changed mid conversion");
  a_if_select: assert property (serial_mode |->
    !parallel_word_mode && !parallel_byte_mode)
    else $error("serial and parallel both on");
  a_word_byte: assert property (!serial_mode |->
    parallel_word_mode ^ parallel_byte_mode)
    else $error("word byte mode wrong");
  a_daisy_serial: assert property (daisy_chain_mode |-> serial_mode)
    else $error("daisy without serial");
  a_buf_group: assert property (&ref_buffer_enable || ~|ref_buffer_enable)
    else $error("buffers split");
  // Main scenarios reached
  c_conv_done: cover property ($fell(busy));
  c_daisy: cover property (daisy_chain_mode);
  c_byte: cover property (parallel_byte_mode);
endmodule
bind arc_config arc_config_sva u_arc_config_sva (
  .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .pair_range_active(pair_range_active),
  .ref_buffer_enable(ref_buffer_enable),
  .parallel_word_mode(parallel_word_mode),
  .parallel_byte_mode(parallel_byte_mode), .serial_mode(serial_mode),
  .daisy_chain_mode(daisy_chain_mode), .busy(busy),
  .result_code(result_code));

/* tb/arc_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host driving the parallel control write pins
// ------------------------------------------------------------
module arc_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Parallel write pins
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic [7:0]      db_upper
);
  // Idle: deselected
  initial begin
    {cs_n, wr_n, rd_n} = 3'b111;
    db_upper = 8'h00;
  end
  // One control write; rd_lvl low gives a refused write
  task automatic write_ctrl(input logic [7:0] b, input logic rd_lvl);
    @(posedge sys_clk);
    {cs_n, wr_n, rd_n} <= {2'b00, rd_lvl};
    db_upper <= b;
    repeat (4) @(posedge sys_clk);
    wr_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Released bus shows the inverse
    {cs_n, rd_n} <= 2'b11;
    db_upper <= ~b;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

/* tb/arc_config_tb_top.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module arc_config_tb_top;
  import arc_pkg::*;
  logic sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy;
  logic range_pin, hw_sw_select, internal_ref_enable_pin;
  logic buffer_disable_pin, serial_parallel_select, word_byte_select;
  logic daisy_chain_pin, conversion_trigger, cs_n, wr_n, rd_n;
  logic internal_ref_on, parallel_word_mode, parallel_byte_mode;
  logic serial_mode, daisy_chain_mode;
  logic [7:0]  wb_adr_i, db_upper;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [16:0] sample_in;
  logic [2:0]  pair_range_active, ref_buffer_enable;
  logic [15:0] result_code;
  int n_errors, tests_run;
  arc_config #(.RES_BITS(RES_16)) u_arc_config (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .range_pin(range_pin),
    .hw_sw_select(hw_sw_select),
    .internal_ref_enable_pin(internal_ref_enable_pin),
    .buffer_disable_pin(buffer_disable_pin),
    .serial_parallel_select(serial_parallel_select),
    .word_byte_select(word_byte_select),
    .daisy_chain_pin(daisy_chain_pin),
    .conversion_trigger(conversion_trigger), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .db_upper(db_upper), .sample_in(sample_in),
    .pair_range_active(pair_range_active),
    .internal_ref_on(internal_ref_on),
    .ref_buffer_enable(ref_buffer_enable),
    .parallel_word_mode(parallel_word_mode),
    .parallel_byte_mode(parallel_byte_mode), .serial_mode(serial_mode),
    .daisy_chain_mode(daisy_chain_mode), .busy(busy),
    .result_code(result_code));
  arc_host_model u_arc_host_model (.sys_clk(sys_clk), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .db_upper(db_upper));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo(string nm);
    chk(nm, 32'h1, 32'h0);
    close_out();
  endtask
  // Classic single cycle, waits for ack
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (i == 20) tmo("ack");
  endtask
  // Strap pins: hs sp wb dc rng ref bufdis, then let syncs settle
  task automatic setp(logic [6:0] p);
    @(posedge sys_clk);
    {hw_sw_select, serial_parallel_select, word_byte_select,
     daisy_chain_pin, range_pin, internal_ref_enable_pin,
     buffer_disable_pin} <= p;
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic conv_start(logic [16:0] s);
    int i;
    @(posedge sys_clk);
    sample_in <= s;
    conversion_trigger <= 1'b1;
    for (i = 0; i < 10 && busy !== 1'b1; i++) @(posedge sys_clk);
    if (i == 10) tmo("busy rise");
  endtask
  task automatic conv_end();
    int i;
    for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge sys_clk);
    if (i == 400) tmo("busy fall");
    conversion_trigger <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic t_reset();
    chk("ref on", 0, internal_ref_on);
    chk("buffers", 7, ref_buffer_enable);
    chk("word", 1, parallel_word_mode);
    wb(0, OFS_CTRL, 0);
    chk("ctrl", 0, q);
  endtask
  task automatic t_hw_pins();
    setp(7'b0000011);
    chk("ref on", 1, internal_ref_on);
    chk("buffers par", 7, ref_buffer_enable);
    setp(7'b0101011);
    chk("buffers ser", 0, ref_buffer_enable);
    chk("serial", 1, serial_mode);
    chk("daisy", 1, daisy_chain_mode);
    setp(7'b0010000);
    chk("byte", 1, parallel_byte_mode);
    chk("ser off", 0, serial_mode);
  endtask
  task automatic t_sw_bus();
    logic [31:0] st;
    st = (1 << ST_REF_ON) | (1 << ST_WORD) | (1 << ST_SW_MODE);
    setp(7'b1000000);
    wb(1, OFS_CTRL, 32'h0000_0003);
    repeat (4) @(posedge sys_clk);
    chk("sw ref", 1, internal_ref_on);
    chk("sw buf", 0, ref_buffer_enable);
    wb(0, OFS_STATUS, 0);
    chk("status", st, q);
    wb(1, 8'h40, 32'h0000_00FF);
    wb(0, 8'h40, 0);
    chk("unmapped", 0, q);
    wb(0, OFS_CTRL, 0);
    chk("ctrl back", 3, q);
  endtask
  task automatic t_pin_write();
    u_arc_host_model.write_ctrl(8'h1C, 1'b1);
    wb(0, OFS_CTRL, 0);
    chk("pin wr", 32'h1C, q);
    u_arc_host_model.write_ctrl(8'h00, 1'b0);
    wb(0, OFS_CTRL, 0);
    chk("rd low", 32'h1C, q);
  endtask
  task automatic t_ranges();
    wb(1, OFS_CTRL, 32'h0000_0014);
    conv_start(0);
    wb(1, OFS_CTRL, 0);
    conv_end();
    chk("pairs 101", 5, pair_range_active);
    conv_start(0);
    conv_end();
    chk("pairs 000", 0, pair_range_active);
    setp(7'b0000100);
    conv_start(0);
    conv_end();
    chk("pin all", 7, pair_range_active);
  endtask
  task automatic t_codes();
    logic [16:0] s [6] = '{17'h00000, 17'h00001, 17'h1FFFF,
                           17'h1FFFD, 17'h10000, 17'h0FFFF};
    logic [15:0] e [6] = '{16'h0000, 16'h0001, 16'h0000,
                           16'hFFFF, 16'h8000, 16'h7FFF};
    for (int k = 0; k < 6; k++) begin
      conv_start(s[k]);
      conv_end();
      chk("code", e[k], result_code);
      wb(0, OFS_RESULT, 0);
      chk("code rd", {16'h0000, e[k]}, q);
    end
  endtask
  initial begin
    {reset, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b1000;
    {wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    {range_pin, hw_sw_select, internal_ref_enable_pin} = 3'b000;
    {buffer_disable_pin, serial_parallel_select} = 2'b00;
    {word_byte_select, daisy_chain_pin, conversion_trigger} = 3'b000;
    sample_in = '0;
    n_errors = 0;
    tests_run = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (6) @(posedge sys_clk);
    t_reset();
    t_hw_pins();
    t_sw_bus();
    t_pin_write();
    t_ranges();
    t_codes();
    close_out();
  end
endmodule
